// ### logic/gate_spi_defines.vh
// Constants shared by the gate driver serial port and enable sequencer.
`ifndef GATE_SPI_DEFINES_VH
`define GATE_SPI_DEFINES_VH

`define CLK_PERIOD_NS 100
`define QUICK_RST_NS 10000
`define FULL_RST_NS 20000
`define LOW_CNT_W 8

`define WORD_W 16
`define DATA_W 11
`define ADDR_W 4
`define BIT_CNT_W 5
`define WORD_BITS 5'h10
`define WORD_OVER 5'h11
`define RW_BIT 15
`define ADDR_HI 14
`define ADDR_LO 11
`define RW_READ 1'b1

`define ADDR_STAT1 4'h0
`define ADDR_STAT2 4'h1
`define ADDR_CTRL1 4'h2
`define ADDR_CTRL2 4'h3
`define CTRL1_RST 11'h000
`define CTRL2_RST 11'h000
`define GATE_RST_BIT 2
`define COND_W 10
`define FAULT_SUM_BIT 10
`define SUPPLY_UV_HI_BIT 9
`define SUPPLY_UV_LO_BIT 8
`define OVERTEMP_BIT 7

`define AXI_AW 5
`define REG_STATE 5'h00
`define REG_CTRL1 5'h04
`define REG_CTRL2 5'h08
`define REG_STAT1 5'h0C
`define REG_INJECT 5'h10
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ### logic/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk_i) begin
        if (!rst_n_i) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_i[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign sync_o = sync_ff;
endmodule

// ### logic/gate_spi_ctrl.v
// Serial control port, enable sequencing and fault latches of a gate driver.
// Functional notes
// (R1) Command word: 16 bits, rw flag on top, four address, eleven data.
// (R2) Response word: fault flag bit 15, address 14..11, data 10..0.
// (R3) After an invalid frame the response is flag one, all else zero.
// (R4) Master keeps clock low at select edges and gives sixteen clocks.
// (R5) Select high: clock and input ignored, serial output released.
// (R6) Select falling enables output and loads response for previous command.
// (R7) One response bit leaves per rising clock edge, MSB first.
// (R8) One command bit is sampled per falling clock edge, MSB first.
// (R9) Pauses between clock pulses are allowed while select stays low.
// (R10) Not exactly sixteen clocks: frame error, write dropped, flag reported.
// (R11) Sixteenth clock or select rise moves input word to latch for decode.
// (R12) Read returns the addressed register in the following response.
// (R13) Write returns the first fault status register in the following response.
// (R14) Rw flag zero means write, one means read.
// (R15) Driver fault reset control bit clears itself after being written one.
// (R16) Gates stay low until enable rises and no faults are present; the code holds them low only on undervoltage, overtemperature, overvoltage.
// (R17) Enable low means no serial access; full reset restores defaults.
// (R18) Enable rising clears gate faults and status registers.
// (R19) Enable falling stops gates at once, other blocks after ten us.
// (R20) Enable low under ten us is a quick reset; serial keeps working.
// (R21) Controller holds enable low over twenty us for a full reset.
// (R22) Controller never applies enable low pulses of ten to twenty us.
// (R23) Serial fault reset clears only gate faults and status registers.
// (R24) Supply overvoltage fault clears only after enable low over twenty us.
// (R25) Enable toggle clears latched faults unless their condition persists.
`timescale 1ns/100ps
`include "gate_spi_defines.vh"
module gate_spi_ctrl #(
  parameter [3:0] DEVICE_ID = 4'h5
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire spi_sclk_i,
  input wire serial_select_n_i,
  input wire spi_sdi_i,
  output wire spi_sdo_o,
  output wire spi_sdo_oe_o,
  input wire gate_enable_i,
  input wire [`COND_W-1:0] fault_cond_i,
  input wire gate_supply_overvoltage_i,
  output wire gate_on_o,
  output wire blocks_on_o,
  input wire [`AXI_AW-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`AXI_AW-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  // The device ID value is arbitrary.
  localparam integer QUICK_CYC = `QUICK_RST_NS / `CLK_PERIOD_NS;
  localparam integer FULL_CYC = `FULL_RST_NS / `CLK_PERIOD_NS;
  localparam [`LOW_CNT_W-1:0] QUICK_C = QUICK_CYC[`LOW_CNT_W-1:0];
  localparam [`LOW_CNT_W-1:0] FULL_C = FULL_CYC[`LOW_CNT_W-1:0];
  localparam [`LOW_CNT_W-1:0] LOW_SAT = FULL_C + 8'h01;
  localparam SW = 5 + `COND_W;
  wire [SW-1:0] pins_s;
  wire sclk_s, sel_n_s, sdi_s, en_s, ov_pin_s;
  wire [`COND_W-1:0] cond_pin_s;
  pin_sync #(
    .W(SW)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({gate_supply_overvoltage_i, fault_cond_i, gate_enable_i,
      spi_sdi_i, serial_select_n_i, spi_sclk_i}),
    .sync_o(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign sel_n_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign en_s = pins_s[3];
  assign cond_pin_s = pins_s[SW-2:4];
  assign ov_pin_s = pins_s[SW-1];
  reg sclk_d_ff, sel_d_ff, en_d_ff;
  reg [`LOW_CNT_W-1:0] low_cnt_ff;
  reg blocks_on_ff, run_ff, gate_on_ff;
  reg [`COND_W-1:0] st_ff, inject_ff;
  reg ov_ff;
  reg [`DATA_W-1:0] ctrl1_ff, ctrl2_ff;
  reg [`WORD_W-1:0] rx_ff, tx_ff, hold_ff;
  reg [`BIT_CNT_W-1:0] cnt_ff;
  reg act_ff, sdo_ff, sdo_oe_ff, prv_err_ff, prv_rd_ff;
  reg [`ADDR_W-1:0] prv_addr_ff;
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire sel_fall = ~sel_n_s & sel_d_ff;
  wire sel_rise = sel_n_s & ~sel_d_ff;
  wire en_rise = en_s & ~en_d_ff;
  wire full_rst = en_rise & (low_cnt_ff > FULL_C);
  wire [`COND_W-1:0] cond = cond_pin_s | inject_ff;
  wire frame_end = act_ff & sel_rise;
  wire frame_ok = frame_end & (cnt_ff == `WORD_BITS);
  wire [`ADDR_W-1:0] hold_addr = hold_ff[`ADDR_HI:`ADDR_LO];
  wire do_wr = frame_ok & (hold_ff[`RW_BIT] != `RW_READ);
  wire gate_rst = do_wr & (hold_addr == `ADDR_CTRL1) &
    hold_ff[`GATE_RST_BIT];
  wire shut = cond[`SUPPLY_UV_HI_BIT] | cond[`SUPPLY_UV_LO_BIT] |
    st_ff[`OVERTEMP_BIT] | ov_ff;
  wire [`DATA_W-1:0] stat1 = {(|st_ff) | ov_ff, st_ff};
  wire [`DATA_W-1:0] stat2 = {3'h0, ov_ff, 3'h0, DEVICE_ID};
  reg [`DATA_W-1:0] rd_mux;
  reg [`WORD_W-1:0] resp;

  always @* begin
    case (prv_addr_ff)
      `ADDR_STAT1: rd_mux = stat1;
      `ADDR_STAT2: rd_mux = stat2;
      `ADDR_CTRL1: rd_mux = ctrl1_ff;
      `ADDR_CTRL2: rd_mux = ctrl2_ff;
      default: rd_mux = 11'h000;
    endcase
    if (prv_err_ff) begin
      resp = {1'b1, 15'h0000}; // (R3)
    end else if (prv_rd_ff) begin
      resp = {1'b0, prv_addr_ff, rd_mux}; // (R12) (R2)
    end else begin
      resp = {1'b0, `ADDR_STAT1, stat1}; // (R13)
    end
  end

  // Enable pin sequencing: low time decides quick or full reset.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_d_ff <= 1'b0;
      sel_d_ff <= 1'b1;
      en_d_ff <= 1'b1;
      low_cnt_ff <= LOW_SAT;
      blocks_on_ff <= 1'b0;
      run_ff <= 1'b0;
      gate_on_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      sel_d_ff <= sel_n_s;
      en_d_ff <= en_s;
      if (en_s) begin
        low_cnt_ff <= 8'h00;
      end else if (low_cnt_ff != LOW_SAT) begin
        low_cnt_ff <= low_cnt_ff + 8'h01;
      end
      if (en_rise) begin
        blocks_on_ff <= 1'b1; // (R18)
        run_ff <= 1'b1; // (R16)
      end else if (!en_s) begin
        run_ff <= 1'b0; // (R19)
        if (low_cnt_ff >= QUICK_C) begin // (R20)
          blocks_on_ff <= 1'b0; // (R19) (R17)
        end
      end
      // Gating with the live enable level turns gates off without waiting.
      gate_on_ff <= run_ff & en_s & ~shut; // (R16) (R19)
    end
  end

  // Fault latches; a condition still present re-sets its bit on a clear.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_ff <= 10'h000;
      ov_ff <= 1'b0;
    end else begin
      if (en_rise | gate_rst) begin
        st_ff <= cond; // (R18) (R23) (R25)
      end else begin
        st_ff <= st_ff | cond;
      end
      if (full_rst) begin
        ov_ff <= ov_pin_s; // (R24)
      end else begin
        ov_ff <= ov_ff | ov_pin_s; // (R24)
      end
    end
  end

  // Serial slave, sampled on the system clock. Clock edges closer than
  // one system clock apart can be missed, which bounds the serial rate.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      hold_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      act_ff <= 1'b0;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
      prv_err_ff <= 1'b0;
      prv_rd_ff <= 1'b0;
      prv_addr_ff <= 4'h0;
      ctrl1_ff <= `CTRL1_RST;
      ctrl2_ff <= `CTRL2_RST;
    end else if (full_rst) begin
      act_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
      prv_err_ff <= 1'b0;
      prv_rd_ff <= 1'b0;
      prv_addr_ff <= 4'h0;
      ctrl1_ff <= `CTRL1_RST; // (R17)
      ctrl2_ff <= `CTRL2_RST; // (R17)
    end else if (!blocks_on_ff) begin
      act_ff <= 1'b0; // (R17)
      sdo_oe_ff <= 1'b0;
    end else if (sel_n_s) begin
      act_ff <= 1'b0; // (R5)
      sdo_oe_ff <= 1'b0; // (R5)
      cnt_ff <= 5'h00;
      if (frame_end) begin
        prv_err_ff <= ~frame_ok; // (R10)
        if (frame_ok) begin
          prv_rd_ff <= (hold_ff[`RW_BIT] == `RW_READ); // (R14)
          prv_addr_ff <= hold_addr; // (R11)
        end
        if (do_wr && hold_addr == `ADDR_CTRL1) begin
          ctrl1_ff <= hold_ff[`DATA_W-1:0] &
            ~(11'h001 << `GATE_RST_BIT); // (R15)
        end
        if (do_wr && hold_addr == `ADDR_CTRL2) begin
          ctrl2_ff <= hold_ff[`DATA_W-1:0]; // (R1)
        end
      end
    end else if (sel_fall) begin
      act_ff <= 1'b1;
      sdo_oe_ff <= 1'b1; // (R6)
      tx_ff <= resp; // (R6)
      sdo_ff <= resp[`WORD_W-1];
      cnt_ff <= 5'h00;
    end else if (act_ff) begin
      // No timeout between edges, so split byte transfers work.
      if (sclk_rise) begin
        tx_ff <= {tx_ff[`WORD_W-2:0], 1'b0}; // (R7) (R9)
        sdo_ff <= tx_ff[`WORD_W-2]; // (R7)
      end
      if (sclk_fall) begin
        rx_ff <= {rx_ff[`WORD_W-2:0], sdi_s}; // (R8)
        if (cnt_ff != `WORD_OVER) begin
          cnt_ff <= cnt_ff + 5'h01; // (R10)
        end
        if (cnt_ff == `WORD_BITS - 5'h01) begin
          hold_ff <= {rx_ff[`WORD_W-2:0], sdi_s}; // (R11)
        end
      end
    end
  end

  // Register slave on the system bus.
  reg aw_rdy_ff, w_rdy_ff, aw_got_ff, w_got_ff;
  reg [`AXI_AW-1:0] waddr_ff;
  reg [31:0] wdata_ff, rdata_ff, axi_rd;
  reg [3:0] wstrb_ff;
  reg bvalid_ff, ar_rdy_ff, rvalid_ff, axi_rd_ok;
  reg [1:0] bresp_ff, rresp_ff;

  wire aw_hs = s_axi_awvalid_i & aw_rdy_ff;
  wire w_hs = s_axi_wvalid_i & w_rdy_ff;
  wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_inj = wr_go & (waddr_ff == `REG_INJECT);

  always @* begin
    axi_rd_ok = 1'b1;
    case (s_axi_araddr_i)
      `REG_STATE: axi_rd = {28'h0000000, ov_ff, prv_err_ff,
        blocks_on_ff, gate_on_ff};
      `REG_CTRL1: axi_rd = {21'h000000, ctrl1_ff};
      `REG_CTRL2: axi_rd = {21'h000000, ctrl2_ff};
      `REG_STAT1: axi_rd = {21'h000000, stat1};
      `REG_INJECT: axi_rd = {22'h000000, inject_ff};
      default: begin
        axi_rd = 32'h00000000;
        axi_rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aw_rdy_ff <= 1'b1;
      w_rdy_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 5'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      inject_ff <= 10'h000;
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_rdy_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_rdy_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (waddr_ff == `REG_STATE || waddr_ff == `REG_CTRL1 ||
            waddr_ff == `REG_CTRL2 || waddr_ff == `REG_STAT1 || wr_inj) begin
          bresp_ff <= `RESP_OKAY;
        end else begin
          bresp_ff <= `RESP_DECERR;
        end
        if (wr_inj && wstrb_ff[0]) begin
          inject_ff[7:0] <= wdata_ff[7:0];
        end
        if (wr_inj && wstrb_ff[1]) begin
          inject_ff[9:8] <= wdata_ff[9:8];
        end
      end
      if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
        aw_rdy_ff <= 1'b1;
        w_rdy_ff <= 1'b1;
      end
      if (s_axi_arvalid_i && ar_rdy_ff) begin
        ar_rdy_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= axi_rd;
        rresp_ff <= axi_rd_ok ? `RESP_OKAY : `RESP_DECERR;
      end
      if (rvalid_ff && s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
        ar_rdy_ff <= 1'b1;
      end
    end
  end

  assign spi_sdo_o = sdo_ff;
  assign spi_sdo_oe_o = sdo_oe_ff;
  assign gate_on_o = gate_on_ff;
  assign blocks_on_o = blocks_on_ff;
  assign s_axi_awready_o = aw_rdy_ff;
  assign s_axi_wready_o = w_rdy_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = ar_rdy_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
endmodule

// ### bench/gate_spi_ctrl_assertions.sv
// Timing properties of the gate driver serial port and enable sequencing.
`timescale 1ns/100ps
module gate_spi_ctrl_assertions (
  input wire mclk_i,
  input wire rst_n_i,
  input wire serial_select_n_i,
  input wire spi_sdo_oe_o,
  input wire gate_enable_i,
  input wire gate_supply_overvoltage_i,
  input wire gate_on_o,
  input wire blocks_on_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_idle_released: assert property (
    serial_select_n_i [*6] |-> !spi_sdo_oe_o) else $error("sdo driven");
  a_off_no_serial: assert property (
    !blocks_on_o [*2] |-> !spi_sdo_oe_o) else $error("sdo while off");
  a_gate_needs_blocks: assert property (
    gate_on_o |-> blocks_on_o) else $error("gate on while off");
  a_gate_stops_fast: assert property (
    $fell(gate_enable_i) |-> ##[1:4] !gate_on_o) else $error("gate late");
  // The ten us quick reset window means blocks must outlive the edge by several cycles.
  a_quick_keeps_blocks: assert property (
    $fell(gate_enable_i) && blocks_on_o |=> blocks_on_o [*8])
    else $error("blocks dropped early");
  a_enable_wakes: assert property (
    $rose(gate_enable_i) |-> ##[2:6] blocks_on_o) else $error("no wake");
  a_ov_stops_gate: assert property (
    gate_supply_overvoltage_i [*5] |-> !gate_on_o) else $error("ov gate");
  a_select_drives: assert property (
    $fell(serial_select_n_i) && blocks_on_o |-> ##[1:5] spi_sdo_oe_o)
    else $error("sdo not enabled");
  a_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read late");
  a_bresp_holds: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
endmodule
bind gate_spi_ctrl gate_spi_ctrl_assertions u_chk (.mclk_i, .rst_n_i,
  .serial_select_n_i, .spi_sdo_oe_o, .gate_enable_i,
  .gate_supply_overvoltage_i, .gate_on_o, .blocks_on_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_bvalid_o, .s_axi_bready_i);

// ### bench/spi_master_model.sv
// Serial master model that frames command words to the gate driver port.
`timescale 1ns/100ps
module spi_master_model (
  output logic sclk_o,
  output logic sel_n_o,
  output logic sdi_o,
  input wire sdo_i,
  input wire sdo_oe_i
);
  logic last = 1'b0;
  // A released sdo reads inverted so a stale level never passes.
  wire line = sdo_oe_i ? sdo_i : ~last;
  always @(sdo_i or sdo_oe_i) if (sdo_oe_i) last = sdo_i;
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Sampling just before each rise leaves the slow sync path its margin.
  task automatic frame(input logic [15:0] c, input int n, input bit gap,
      output logic [15:0] r);
    r = 16'h0000;
    sel_n_o = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      if (i < 16) r = {r[14:0], line};
      sclk_o = 1'b1;
      sdi_o = c[15];
      c = {c[14:0], 1'b0};
      #400;
      sclk_o = 1'b0;
      #400;
      if (gap && i == 7) #3000;
    end
    sel_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #2000;
  endtask
endmodule

// ### bench/tb_gate_spi_ctrl.sv
// Self-checking bench for the gate driver serial port and enable logic.
`timescale 1ns/100ps
`include "gate_spi_defines.vh"
module tb_gate_spi_ctrl;
  // Device code value is arbitrary.
  localparam [3:0] ID = 4'hA;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gate_enable_i = 1'b0;
  logic gate_supply_overvoltage_i = 1'b0;
  logic [9:0] fault_cond_i = 10'h000;
  logic [4:0] s_axi_awaddr_i = 5'h00;
  logic [4:0] s_axi_araddr_i = 5'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  wire spi_sclk_i, serial_select_n_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o;
  wire gate_on_o, blocks_on_o, s_axi_awready_o, s_axi_wready_o;
  wire s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 65;
  logic [10:0] d;
  logic [15:0] s_got;
  logic [33:0] qa[$];
  logic [15:0] qs[$];
  event s_ev;
  always #50 mclk_i = ~mclk_i;
  gate_spi_ctrl #(.DEVICE_ID(ID)) u_dut (.mclk_i, .rst_n_i, .spi_sclk_i,
    .serial_select_n_i, .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o,
    .gate_enable_i, .fault_cond_i, .gate_supply_overvoltage_i, .gate_on_o,
    .blocks_on_o, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i);
  spi_master_model u_mst (.sclk_o(spi_sclk_i), .sel_n_o(serial_select_n_i),
    .sdi_o(spi_sdi_i), .sdo_i(spi_sdo_o), .sdo_oe_i(spi_sdo_oe_o));
  task automatic cmp(input string nm, input logic [33:0] e,
      input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(negedge mclk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i)
      cmp("axi read", qa.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o && s_axi_bready_i)
      cmp("axi write", qa.pop_front(), {s_axi_bresp_o, 32'h0});
  end
  always @(s_ev) cmp("spi word", {18'h0, qs.pop_front()}, {18'h0, s_got});
  task automatic axi(input bit wr, input logic [4:0] a,
      input logic [31:0] v, input logic [33:0] e);
    bit ta, tw, tr, dn;
    int k;
    dn = 1'b0;
    qa.push_back(e);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_araddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= wr;
    s_axi_wvalid_i <= wr;
    s_axi_bready_i <= wr;
    s_axi_arvalid_i <= !wr;
    s_axi_rready_i <= !wr;
    for (k = 0; k < 40 && !dn; k++) begin
      @(negedge mclk_i);
      ta = s_axi_awready_o;
      tw = s_axi_wready_o;
      tr = s_axi_arready_o;
      dn = s_axi_bvalid_o || s_axi_rvalid_o;
      @(posedge mclk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      if (tr) s_axi_arvalid_i <= 1'b0;
    end
    s_axi_bready_i <= 1'b0;
    s_axi_rready_i <= 1'b0;
    if (!dn) begin
      n_errors++;
      wrap_up;
    end
  endtask
  task automatic spi(input logic [15:0] c, input int n, input bit gap,
      input logic [15:0] e, input bit chk = 1);
    logic [15:0] r;
    if (chk) qs.push_back(e);
    // Link edges then fall on falling system clock edges, off the sampling edge.
    @(negedge mclk_i);
    u_mst.frame(c, n, gap, r);
    s_got = r;
    if (chk) -> s_ev;
  endtask
  task automatic en_low(input int n);
    @(posedge mclk_i);
    gate_enable_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    gate_enable_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
  endtask
  task automatic gate(input logic e);
    @(negedge mclk_i);
    cmp("gate on", {33'h0, e}, {33'h0, gate_on_o});
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    wrap_up;
  end
  initial begin
    d = 11'($random(seed));
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    gate_enable_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    axi(0, `REG_STATE, 0, 34'h3);
    axi(1, 5'h14, 0, {`RESP_DECERR, 32'h0});
    axi(0, 5'h14, 0, {`RESP_DECERR, 32'h0});
    spi({1'b0, `ADDR_CTRL2, d}, 16, 0, 16'h0);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 1, 16'h0);
    spi({1'b1, `ADDR_STAT2, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL2, d});
    spi({1'b0, `ADDR_CTRL2, ~d}, 15, 0,
      {2'b0, `ADDR_STAT2, 7'h0, ID[3:1]});
    axi(1, `REG_INJECT, 1, 0);
    axi(1, `REG_INJECT, 0, 0);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 17, 0, 16'h8000);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, 16'h8000);
    spi({1'b1, `ADDR_STAT1, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL2, d});
    spi({1'b0, `ADDR_CTRL1, 11'h004}, 16, 0,
      {1'b0, `ADDR_STAT1, 11'h401});
    spi({1'b1, `ADDR_CTRL1, 11'h0}, 16, 0, 16'h0);
    spi({1'b1, `ADDR_STAT1, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL1, 11'h0});
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, {1'b0, `ADDR_STAT1, 11'h0});
    spi({1'b1, `ADDR_STAT1, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL2, d});
    en_low(50);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, {1'b0, `ADDR_STAT1, 11'h0});
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL2, d});
    axi(0, `REG_CTRL2, 0, {23'h000000, d});
    gate_supply_overvoltage_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    gate_supply_overvoltage_i <= 1'b0;
    gate(0);
    axi(0, `REG_STATE, 0, 34'hA);
    en_low(50);
    gate(0);
    en_low(250);
    gate(1);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, 16'h0);
    spi({1'b1, `ADDR_CTRL2, 11'h0}, 16, 0, {1'b0, `ADDR_CTRL2, 11'h0});
    axi(0, `REG_CTRL2, 0, 34'h0);
    @(posedge mclk_i);
    wrap_up;
  end
endmodule
